//--- src/fbp_flash_protect.v
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "fbp_map.vh"
// What this block does
// - Protect from decoded start up to top
// - Refuse high voltage enable on protected target
// - All zeros protects whole array
// - All ones leaves array unprotected
// - High voltage refused on protect byte target unless ones
// - Mass erase disabled under any protection if mass was selected before the HV write
// - High voltage on protect byte target needs test voltage
// - Protect byte changes only by program or erase
// - Start address is 11, byte, six zeros
// - Start address on 64-byte boundary
// - BE00 to BFFF protected unless all ones
// - High voltage needs program or erase select set before the request
// - Erase page is 64 aligned bytes
module fbp_flash_protect (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [`FBP_ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // Array side: bus writes into flash space latch the target
  input wire flashWrite,
  input wire [15:0] flashAddr,
  input wire [7:0] flashWrData,
  // Address of the protect byte within the array
  input wire [15:0] protectByteAddr,
  // Level from the interrupt pin high-voltage detector
  input wire testHighVoltage,
  // Array controls
  output reg programSelect,
  output reg eraseSelect,
  output reg massSelect,
  output reg highVoltageEnable,
  output wire massEraseAllowed
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] protectStartByte_q;
  reg [15:0] targetAddr_q;
  reg targetLatched_q;
  reg protectRead_q;
  reg refused_q;
  wire [15:0] startAddr;
  wire targetProtected;
  wire anyProtected;

  fbp_range_check uRange (
    .protectStartField(protectStartByte_q),
    .targetAddr(targetAddr_q),
    .protectStartAddr(startAddr),
    .targetProtected(targetProtected),
    .anyProtected(anyProtected)
  );

  function isReg;
    input [`FBP_ADDR_W-1:0] a;
    input [`FBP_ADDR_W-1:0] off;
    begin
      isReg = (a == off);
    end
  endfunction

  wire ctrlWrite = regWrite && isReg(regAddr, `FBP_OFF_CTRL);
  wire wantPgm = regWrData[`FBP_CTRL_PGM];
  wire wantErase = regWrData[`FBP_CTRL_ERASE];
  wire wantMass = regWrData[`FBP_CTRL_MASS];
  wire wantHv = regWrData[`FBP_CTRL_HIGH_VOLTAGE_ENABLE];
  wire targetIsProtectByte = (targetAddr_q == protectByteAddr);
  assign massEraseAllowed = !anyProtected;

  // Refusal terms for a requested high voltage enable
  wire massBlocked = massSelect && eraseSelect && anyProtected;
  wire byteBlocked = targetIsProtectByte && (anyProtected || !testHighVoltage);
  wire selOk = programSelect || eraseSelect;
  wire seqOk = selOk && protectRead_q && targetLatched_q;
  wire hvRefuse = targetProtected || massBlocked || byteBlocked || !seqOk;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      programSelect <= 1'b0;
      eraseSelect <= 1'b0;
      massSelect <= 1'b0;
      highVoltageEnable <= 1'b0;
      refused_q <= 1'b0;
    end else if (ctrlWrite) begin
      // Program and erase interlocked: both requested keeps neither new
      if (!(wantPgm && wantErase)) begin
        programSelect <= wantPgm && !eraseSelect;
        eraseSelect <= wantErase && !programSelect;
      end
      massSelect <= wantMass;
      if (wantHv && !highVoltageEnable) begin
        highVoltageEnable <= !hvRefuse;
        refused_q <= hvRefuse;
      end else if (!wantHv) begin
        highVoltageEnable <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sequence tracking and target latch
  // ----------------------------------------
  wire selRising = ctrlWrite && (wantPgm || wantErase) && !(programSelect || eraseSelect);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      protectRead_q <= 1'b0;
      targetLatched_q <= 1'b0;
      targetAddr_q <= 16'h0000;
    end else begin
      if (selRising || !selOk) begin
        protectRead_q <= 1'b0;
        targetLatched_q <= 1'b0;
      end else begin
        if (regRead && isReg(regAddr, `FBP_OFF_PROTECT)) begin
          protectRead_q <= 1'b1;
        end
        // First write after the select bit latches the target
        if (flashWrite && !targetLatched_q && !highVoltageEnable) begin
          targetAddr_q <= flashAddr;
          targetLatched_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Protect byte image: changes only by a real array program/erase
  // ----------------------------------------
  wire pgmByte = programSelect && highVoltageEnable && flashWrite && (flashAddr == protectByteAddr);
  wire eraseByte = eraseSelect && highVoltageEnable && !ctrlWrite &&
                   ((targetAddr_q & `FBP_PAGE_MASK) == (protectByteAddr & `FBP_PAGE_MASK));
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      protectStartByte_q <= `FBP_PROTECT_RESET;
    end else if (eraseByte) begin
      protectStartByte_q <= `FBP_ALL_ONES;
    end else if (pgmByte) begin
      // Programming only clears bits, as flash cells do
      protectStartByte_q <= protectStartByte_q & flashWrData;
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------
  reg [7:0] rdMux;
  always @* begin
    case (regAddr)
      `FBP_OFF_CTRL: rdMux = {4'h0, highVoltageEnable, massSelect, eraseSelect, programSelect};
      `FBP_OFF_STATUS: rdMux = {3'h0, testHighVoltage, anyProtected, targetLatched_q, protectRead_q, refused_q};
      `FBP_OFF_PROTECT: rdMux = protectStartByte_q;
      `FBP_OFF_TGT_HI: rdMux = targetAddr_q[15:8];
      `FBP_OFF_TGT_LO: rdMux = targetAddr_q[7:0];
      `FBP_OFF_START_HI: rdMux = startAddr[15:8];
      `FBP_OFF_START_LO: rdMux = startAddr[7:0];
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule // fbp_flash_protect

//--- src/fbp_map.vh
`ifndef FBP_MAP_VH
`define FBP_MAP_VH
// ----------------------------------------
// Register offsets (8-bit register port)
// ----------------------------------------
`define FBP_ADDR_W 4
`define FBP_OFF_CTRL 4'h0
`define FBP_OFF_STATUS 4'h1
`define FBP_OFF_PROTECT 4'h2
`define FBP_OFF_TGT_HI 4'h3
`define FBP_OFF_TGT_LO 4'h4
`define FBP_OFF_START_HI 4'h5
`define FBP_OFF_START_LO 4'h6
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define FBP_CTRL_PGM 0
`define FBP_CTRL_ERASE 1
`define FBP_CTRL_MASS 2
`define FBP_CTRL_HIGH_VOLTAGE_ENABLE 3
// ----------------------------------------
// Status register bits
// ----------------------------------------
`define FBP_ST_BLOCKED 0
`define FBP_ST_ARMED 1
`define FBP_ST_LATCHED 2
`define FBP_ST_MASSOFF 3
`define FBP_ST_TSTHV 4
// ----------------------------------------
// Protection constants
// ----------------------------------------
`define FBP_ALL_ONES 8'hff
`define FBP_ALL_ZERO 8'h00
`define FBP_PAGE_MASK 16'hffc0
`define FBP_ALWAYS_LO 16'hbe00
`define FBP_ALWAYS_HI 16'hbfff
`define FBP_PROTECT_RESET 8'hff
`endif

//--- src/fbp_range_check.v
`timescale 1ns/100ps
`include "fbp_map.vh"
module fbp_range_check (
  // Protect byte and target
  input wire [7:0] protectStartField,
  input wire [15:0] targetAddr,
  // Decode results
  output wire [15:0] protectStartAddr,
  output wire targetProtected,
  output wire anyProtected
);
  // Bits 15:14 forced to one, 5:0 to zero, so always page aligned
  assign protectStartAddr = {2'b11, protectStartField, 6'h00};
  assign anyProtected = (protectStartField != `FBP_ALL_ONES);
  // Page granularity: compare the page base only
  wire [15:0] pageBase = targetAddr & `FBP_PAGE_MASK;
  wire inRange = (pageBase >= protectStartAddr);
  wire inAlways = (targetAddr >= `FBP_ALWAYS_LO) && (targetAddr <= `FBP_ALWAYS_HI);
  wire allLocked = (protectStartField == `FBP_ALL_ZERO);
  assign targetProtected = anyProtected && (inRange || inAlways || allLocked);
endmodule // fbp_range_check

//--- test/fbp_protect_assertions.sv
`timescale 1ns/100ps
`include "fbp_map.vh"
module fbp_protect_assertions (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [`FBP_ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  // Array side
  input wire flashWrite,
  input wire testHighVoltage,
  input wire programSelect,
  input wire eraseSelect,
  input wire massSelect,
  input wire highVoltageEnable,
  input wire massEraseAllowed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_HV_SEL: assert property ($rose(highVoltageEnable) |-> programSelect || eraseSelect)
    else $error("high voltage without select");
  AST_INTERLOCK: assert property (!(programSelect && eraseSelect))
    else $error("program and erase both selected");
  AST_HV_CAUSE: assert property ($rose(highVoltageEnable) |-> $past(regWrite && regAddr == `FBP_OFF_CTRL))
    else $error("high voltage rose without control write");
  AST_HV_MASS: assert property ($rose(highVoltageEnable) && massSelect && eraseSelect |-> massEraseAllowed)
    else $error("mass erase under protection");
  AST_MASS_RD: assert property (regRead && regAddr == `FBP_OFF_PROTECT && !flashWrite
    |=> (regRdData == 8'hff) == massEraseAllowed) else $error("mass erase flag disagrees");
  AST_START_HI: assert property (regRead && regAddr == `FBP_OFF_START_HI |=> regRdData[7:6] == 2'b11)
    else $error("start address top bits");
  AST_START_LO: assert property (regRead && regAddr == `FBP_OFF_START_LO |=> regRdData[5:0] == 6'h00)
    else $error("start address not page aligned");
  AST_TSTHV: assert property (regRead && regAddr == `FBP_OFF_STATUS |=> regRdData[4] == $past(testHighVoltage))
    else $error("test voltage status wrong");
endmodule // fbp_protect_assertions
bind fbp_flash_protect fbp_protect_assertions fbp_protect_assertions_inst (.*);

//--- test/fbp_cpu_model.sv
`timescale 1ns/100ps
module fbp_cpu_model (
  // Clock
  input wire clock,
  // Flash space writes
  output reg flashWrite,
  output reg [15:0] flashAddr,
  output reg [7:0] flashWrData
);
  initial flashWrite = 1'b0;
  initial flashAddr = 16'h0000;
  initial flashWrData = 8'h00;
  // One write per call; released lines show inverted values
  task put(input [15:0] a, input [7:0] d);
    @(posedge clock);
    flashWrite <= 1'b1;
    flashAddr <= a;
    flashWrData <= d;
    @(posedge clock);
    flashWrite <= 1'b0;
    flashAddr <= ~a;
    flashWrData <= ~d;
  endtask
endmodule // fbp_cpu_model

//--- test/tb.sv
`timescale 1ns/100ps
`include "fbp_map.vh"
module tb;
  localparam [15:0] PBA = 16'hffbe;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [`FBP_ADDR_W-1:0] regAddr = 0;
  reg [7:0] regWrData = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg testHighVoltage = 1'b1;
  wire [7:0] regRdData;
  wire flashWrite, programSelect, eraseSelect, massSelect, highVoltageEnable, massEraseAllowed;
  wire [15:0] flashAddr;
  wire [7:0] flashWrData;
  integer miscompares = 0;
  integer n_tests = 0;
  always #25 clock = ~clock;
  fbp_flash_protect fbp_flash_protect_inst (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .flashWrite(flashWrite), .flashAddr(flashAddr), .flashWrData(flashWrData),
    .protectByteAddr(PBA), .testHighVoltage(testHighVoltage), .programSelect(programSelect),
    .eraseSelect(eraseSelect), .massSelect(massSelect), .highVoltageEnable(highVoltageEnable),
    .massEraseAllowed(massEraseAllowed));
  fbp_cpu_model fbp_cpu_model_inst (.clock(clock), .flashWrite(flashWrite), .flashAddr(flashAddr),
    .flashWrData(flashWrData));
  task chk(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // Select, read protect byte, latch target, then ask for high voltage
  task try(input [7:0] c, input [15:0] a, input [7:0] pb, input hv);
    wr(`FBP_OFF_CTRL, c);
    rd(`FBP_OFF_PROTECT, pb);
    fbp_cpu_model_inst.put(a, 8'hff);
    wr(`FBP_OFF_CTRL, c | 8'h08);
    #1 chk({7'h00, highVoltageEnable}, {7'h00, hv});
  endtask
  task rst;
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  task results;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clock);
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    rst;
    rd(`FBP_OFF_PROTECT, 8'hff);
    rd(4'hf, 8'h00);
    wr(`FBP_OFF_PROTECT, 8'h00);
    rd(`FBP_OFF_PROTECT, 8'hff);
    try(8'h01, 16'hc000, 8'hff, 1'b1);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h01, PBA, 8'hff, 1'b1);
    fbp_cpu_model_inst.put(PBA, 8'h01);
    wr(`FBP_OFF_CTRL, 8'h00);
    rd(`FBP_OFF_PROTECT, 8'h01);
    rd(`FBP_OFF_START_HI, 8'hc0);
    rd(`FBP_OFF_START_LO, 8'h40);
    chk({7'h00, massEraseAllowed}, 8'h00);
    try(8'h01, 16'hc03f, 8'h01, 1'b1);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h01, 16'hc040, 8'h01, 1'b0);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h02, 16'hc07f, 8'h01, 1'b0);
    rd(`FBP_OFF_CTRL, 8'h02);
    rd(`FBP_OFF_STATUS, 8'h1f);
    rd(`FBP_OFF_TGT_HI, 8'hc0);
    rd(`FBP_OFF_TGT_LO, 8'h7f);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h01, 16'hbe00, 8'h01, 1'b0);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h06, 16'hc000, 8'h01, 1'b0);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h01, PBA, 8'h01, 1'b0);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h00, 16'hc000, 8'h01, 1'b0);
    testHighVoltage <= 1'b0;
    rst;
    try(8'h01, PBA, 8'hff, 1'b0);
    wr(`FBP_OFF_CTRL, 8'h00);
    testHighVoltage <= 1'b1;
    try(8'h01, PBA, 8'hff, 1'b1);
    fbp_cpu_model_inst.put(PBA, 8'h00);
    wr(`FBP_OFF_CTRL, 8'h00);
    try(8'h01, 16'hc000, 8'h00, 1'b0);
    results;
  end
endmodule // tb
